// ==== output_initial_level_top.sv ====
// Compact timer core: registers, 10-bit counter, comparators and compare/PWM output control.
`timescale 1ns/1ps
`default_nettype none

module output_initial_level_top (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [2:0] address_in,
  input wire logic [7:0] write_data_in,
  input wire logic write_strobe_in,
  input wire logic read_strobe_in,
  input wire logic count_tick_in,
  output logic [7:0] read_data_out,
  output logic timer_output_pin_out,
  output logic timer_output_pin_oe_n_out,
  output logic compare_a_match_out,
  output logic compare_p_match_out,
  output logic [9:0] count_out
);

  output_initial_level_pkg::output_initial_level_core_state_t state;
  output_initial_level_pkg::output_initial_level_core_state_t next_state;

  logic [1:0] mode_select;
  logic [1:0] output_action;
  logic output_initial_level;
  logic output_invert;
  logic pwm_period_duty_swap;
  logic counter_clear_select;
  logic pin_used;
  logic pwm_active;
  logic counter_on_rise;
  logic write_run;
  logic counting;
  logic a_hit;
  logic p_hit;
  logic clear_now;
  logic [10:0] period_p;
  logic [10:0] duty_value;

  // Compare-P spans 128 counts per step; the zero code stands for the full 1024-count span.
  function automatic logic [10:0] compare_p_span(input logic [2:0] value);
    if (value == 3'h0) begin
      compare_p_span = output_initial_level_pkg::FULL_COUNT_SPAN;
    end else begin
      compare_p_span = {1'b0, value, output_initial_level_pkg::COMPARE_P_STEP_ZEROS};
    end
  endfunction

  // True when the next count would reach the target, so the match ends the current span.
  function automatic logic reaches(input logic [9:0] count, input logic [10:0] target);
    reaches = (11'({1'b0, count}) + 11'h001) == target;
  endfunction

  assign mode_select = state.mode_output_control[output_initial_level_pkg::MODE_SELECT_LSB +: 2];
  assign output_action = state.mode_output_control[output_initial_level_pkg::OUTPUT_ACTION_LSB +: 2];
  assign output_initial_level =
    state.mode_output_control[output_initial_level_pkg::OUTPUT_INITIAL_LEVEL_BIT];
  assign output_invert = state.mode_output_control[output_initial_level_pkg::OUTPUT_INVERT_BIT];
  assign pwm_period_duty_swap =
    state.mode_output_control[output_initial_level_pkg::PWM_PERIOD_DUTY_SWAP_BIT];
  assign counter_clear_select =
    state.mode_output_control[output_initial_level_pkg::COUNTER_CLEAR_SELECT_BIT];

  assign period_p = compare_p_span(state.compare_p_value);

  // Duty compares against the live count; a duty at or above the period gives full duty.
  assign duty_value = pwm_period_duty_swap ? period_p : {1'b0, state.compare_a_value};
  assign pwm_active = {1'b0, state.count} < duty_value;

  assign write_run = write_strobe_in && (address_in == output_initial_level_pkg::ADDR_RUN_CONTROL);
  assign counter_on_rise = write_run && !state.counter_on &&
    write_data_in[output_initial_level_pkg::RUN_COUNTER_ON_BIT];
  assign counting = state.counter_on && count_tick_in;

  // A zero compare-A never raises its match, the counter then simply wraps at the top.
  assign a_hit = counting && (state.compare_a_value != output_initial_level_pkg::COMPARE_A_RESET) &&
    reaches(state.count, {1'b0, state.compare_a_value});
  assign p_hit = counting && reaches(state.count, period_p);

  always_comb begin
    clear_now = 1'b0;
    unique case (mode_select)
      output_initial_level_pkg::MODE_PWM_OUTPUT: begin
        // The clear-select bit is not consulted here; the swap bit picks the period source.
        clear_now = pwm_period_duty_swap ? a_hit : p_hit;
      end
      default: begin
        // With compare-P at zero, p_hit lands on the overflow itself.
        clear_now = counter_clear_select ? a_hit : p_hit;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.read_data = output_initial_level_pkg::READ_UNMAPPED;
    next_state.compare_a_match = a_hit;
    // With A clearing outside PWM, comparator P raises nothing.
    next_state.compare_p_match = p_hit &&
      !(counter_clear_select && mode_select != output_initial_level_pkg::MODE_PWM_OUTPUT);

    // Counter: a tick advances it, a selected match clears it, overflow wraps it.
    if (counting) begin
      if (clear_now) begin
        next_state.count = output_initial_level_pkg::COUNT_RESET;
      end else begin
        next_state.count = state.count + 10'h001;
      end
    end

    // Compare output level; it follows the initial-level bit until the first match whose action is not no-change.
    if (!state.compare_touched) begin
      next_state.compare_level = output_initial_level;
    end
    if (a_hit && mode_select == output_initial_level_pkg::MODE_COMPARE_OUTPUT) begin
      // Driving to the level already held is a no-op, so equal levels need no test.
      unique case (output_action)
        output_initial_level_pkg::ACTION_NO_CHANGE: next_state.compare_level = state.compare_level;
        output_initial_level_pkg::ACTION_LOW: next_state.compare_level = 1'b0;
        output_initial_level_pkg::ACTION_HIGH: next_state.compare_level = 1'b1;
        output_initial_level_pkg::ACTION_TOGGLE: next_state.compare_level = ~state.compare_level;
      endcase
      if (output_action != output_initial_level_pkg::ACTION_NO_CHANGE) begin
        next_state.compare_touched = 1'b1;
      end
    end

    if (write_strobe_in) begin
      unique case (address_in)
        output_initial_level_pkg::ADDR_RUN_CONTROL: begin
          next_state.counter_on = write_data_in[output_initial_level_pkg::RUN_COUNTER_ON_BIT];
          next_state.compare_p_value =
            write_data_in[output_initial_level_pkg::RUN_COMPARE_P_LSB +: output_initial_level_pkg::COMPARE_P_WIDTH];
          if (counter_on_rise) begin
            // Only the rising edge restarts; clearing the bit just freezes the count.
            next_state.count = output_initial_level_pkg::COUNT_RESET;
            next_state.compare_touched = 1'b0;
            next_state.compare_level =
              write_data_in[output_initial_level_pkg::RUN_COUNTER_ON_BIT] ?
              output_initial_level : state.compare_level;
          end
        end
        output_initial_level_pkg::ADDR_MODE_OUTPUT_CONTROL: begin
          // Mode and action changes while running are the software's hazard.
          next_state.mode_output_control = write_data_in;
        end
        output_initial_level_pkg::ADDR_COMPARE_A_LOW: begin
          next_state.compare_a_buffer = write_data_in;
        end
        output_initial_level_pkg::ADDR_COMPARE_A_HIGH: begin
          next_state.compare_a_value = {write_data_in[1:0], state.compare_a_buffer};
        end
        default: begin
          // Counter bytes are read-only and unmapped addresses ignore writes.
          next_state.counter_on = state.counter_on;
        end
      endcase
    end

    if (read_strobe_in) begin
      unique case (address_in)
        output_initial_level_pkg::ADDR_RUN_CONTROL: begin
          next_state.read_data = {4'h0, state.counter_on, state.compare_p_value};
        end
        output_initial_level_pkg::ADDR_MODE_OUTPUT_CONTROL: begin
          next_state.read_data = state.mode_output_control;
        end
        output_initial_level_pkg::ADDR_COUNT_LOW: begin
          next_state.read_data = state.count_buffer;
        end
        output_initial_level_pkg::ADDR_COUNT_HIGH: begin
          // Snapshot the low byte now so the pair reads coherently while counting.
          next_state.read_data = {6'h00, state.count[9:8]};
          next_state.count_buffer = state.count[7:0];
        end
        output_initial_level_pkg::ADDR_COMPARE_A_LOW: begin
          next_state.read_data = state.compare_a_buffer;
        end
        output_initial_level_pkg::ADDR_COMPARE_A_HIGH: begin
          next_state.read_data = {6'h00, state.compare_a_value[9:8]};
          next_state.compare_a_buffer = state.compare_a_value[7:0];
        end
        default: begin
          next_state.read_data = output_initial_level_pkg::READ_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  output_initial_level_pin_stage pin_stage (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .mode_select_in(mode_select),
    .output_action_in(output_action),
    .output_initial_level_in(output_initial_level),
    .output_invert_in(output_invert),
    .compare_level_in(state.compare_level),
    .pwm_active_in(pwm_active),
    .pin_level_out(timer_output_pin_out),
    .pin_used_out(pin_used)
  );

  assign timer_output_pin_oe_n_out = ~pin_used;
  assign read_data_out = state.read_data;
  assign compare_a_match_out = state.compare_a_match;
  assign compare_p_match_out = state.compare_p_match;
  assign count_out = state.count;

endmodule

`default_nettype wire

// ==== output_initial_level_pkg.sv ====
// Package with register map, field layout, mode codes and state types of the compact timer.
//
// Notes on behaviour
// - Mode field: 00 compare output, 10 PWM, 11 timer/counter; 01 undefined.
// - Timer/counter mode leaves the output pin undriven; action field unused.
// - Compare mode, A match: action 00 nothing, 01 low, 10 high, 11 toggle.
// - A match requesting the level already held leaves the pin unchanged.
// - Counter-on rising edge returns the pin to its programmed initial level.
// - PWM mode action: 00 force inactive, 01 force active, 10 waveform; 11 undefined.
// - PWM mode: initial-level bit picks active level; no effect in timer mode.
// - Invert bit at 1 inverts the pin; no effect in timer/counter mode.
// - Swap bit 0: P period, A duty; 1: P duty, A period.
// - Clear-select 1 clears on A match; 0 clears on P match or overflow.
// - Overflow clearing only when all compare-P bits are zero.
// - Clear-select bit ignored in PWM output mode.
// - Counter readable as low byte and high byte, upper six bits zero.
// - Compare-A held writable and readable as low byte and high byte.
// - Low bytes pass an 8-bit buffer moved by high-byte write or read.
// - Counter-on rising clears the counter; falling stops but keeps the count.
// - Compare-P meets counter bits 9 to 7, steps of 128, 000 means 1024.

package output_initial_level_pkg;

  localparam int ADDR_WIDTH = 3;
  localparam int DATA_WIDTH = 8;
  localparam int COUNT_WIDTH = 10;
  localparam int COMPARE_P_WIDTH = 3;

  localparam logic [2:0] ADDR_RUN_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_MODE_OUTPUT_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_COUNT_LOW = 3'h2;
  localparam logic [2:0] ADDR_COUNT_HIGH = 3'h3;
  localparam logic [2:0] ADDR_COMPARE_A_LOW = 3'h4;
  localparam logic [2:0] ADDR_COMPARE_A_HIGH = 3'h5;

  localparam int RUN_COUNTER_ON_BIT = 3;
  localparam int RUN_COMPARE_P_LSB = 0;
  localparam int MODE_SELECT_LSB = 6;
  localparam int OUTPUT_ACTION_LSB = 4;
  localparam int OUTPUT_INITIAL_LEVEL_BIT = 3;
  localparam int OUTPUT_INVERT_BIT = 2;
  localparam int PWM_PERIOD_DUTY_SWAP_BIT = 1;
  localparam int COUNTER_CLEAR_SELECT_BIT = 0;

  localparam logic [7:0] MODE_OUTPUT_CONTROL_RESET = 8'h00;
  localparam logic [9:0] COUNT_RESET = 10'h000;
  localparam logic [9:0] COMPARE_A_RESET = 10'h000;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam logic [1:0] MODE_COMPARE_OUTPUT = 2'h0;
  localparam logic [1:0] MODE_UNDEFINED = 2'h1;
  localparam logic [1:0] MODE_PWM_OUTPUT = 2'h2;
  localparam logic [1:0] MODE_TIMER_COUNTER = 2'h3;

  localparam logic [1:0] ACTION_NO_CHANGE = 2'h0;
  localparam logic [1:0] ACTION_LOW = 2'h1;
  localparam logic [1:0] ACTION_HIGH = 2'h2;
  localparam logic [1:0] ACTION_TOGGLE = 2'h3;

  localparam logic [1:0] PWM_FORCE_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_FORCE_ACTIVE = 2'h1;
  localparam logic [1:0] PWM_WAVEFORM = 2'h2;

  localparam logic [10:0] FULL_COUNT_SPAN = 11'h400;
  localparam logic [6:0] COMPARE_P_STEP_ZEROS = 7'h00;

  typedef struct packed {
    logic counter_on;
    logic [2:0] compare_p_value;
    logic [7:0] mode_output_control;
    logic [9:0] count;
    logic [9:0] compare_a_value;
    logic [7:0] count_buffer;
    logic [7:0] compare_a_buffer;
    logic [7:0] read_data;
    logic compare_level;
    logic compare_touched;
    logic compare_a_match;
    logic compare_p_match;
  } output_initial_level_core_state_t;

  typedef struct packed {
    logic pin_level;
    logic pin_used;
  } output_initial_level_pin_state_t;

endpackage

// ==== output_initial_level_pin_stage.sv ====
// Output pin stage: picks the mode source, applies polarity, registers the pin.
`timescale 1ns/1ps
`default_nettype none

module output_initial_level_pin_stage (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [1:0] mode_select_in,
  input wire logic [1:0] output_action_in,
  input wire logic output_initial_level_in,
  input wire logic output_invert_in,
  input wire logic compare_level_in,
  input wire logic pwm_active_in,
  output logic pin_level_out,
  output logic pin_used_out
);

  output_initial_level_pkg::output_initial_level_pin_state_t state;
  output_initial_level_pkg::output_initial_level_pin_state_t next_state;
  logic pwm_level;
  logic raw_level;

  always_comb begin
    next_state = state;
    // The active level sets what "active" means on the pin.
    pwm_level = output_initial_level_in ? pwm_active_in : ~pwm_active_in;
    unique case (output_action_in)
      output_initial_level_pkg::PWM_FORCE_INACTIVE: raw_level = ~output_initial_level_in;
      output_initial_level_pkg::PWM_FORCE_ACTIVE: raw_level = output_initial_level_in;
      output_initial_level_pkg::PWM_WAVEFORM: raw_level = pwm_level;
      // The undefined code holds the pin where it was.
      default: raw_level = state.pin_level ^ output_invert_in;
    endcase
    unique case (mode_select_in)
      output_initial_level_pkg::MODE_COMPARE_OUTPUT: begin
        next_state.pin_level = compare_level_in ^ output_invert_in;
        next_state.pin_used = 1'b1;
      end
      output_initial_level_pkg::MODE_PWM_OUTPUT: begin
        next_state.pin_level = raw_level ^ output_invert_in;
        next_state.pin_used = 1'b1;
      end
      default: begin
        // Timer/counter and the undefined mode release the pin.
        next_state.pin_level = 1'b0;
        next_state.pin_used = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      // Compare output is the reset mode, so the pin is driven at its low initial level at once.
      state <= '{pin_level: 1'b0, pin_used: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  assign pin_level_out = state.pin_level;
  assign pin_used_out = state.pin_used;

endmodule

`default_nettype wire

// ==== output_initial_level_top_assertions.sv ====
// Concurrent checks on the compact timer core ports.
`timescale 1ns/1ps
`default_nettype none
module output_initial_level_checker (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [2:0] address_in,
  input wire logic [7:0] write_data_in,
  input wire logic write_strobe_in,
  input wire logic read_strobe_in,
  input wire logic count_tick_in,
  input wire logic [7:0] read_data_out,
  input wire logic timer_output_pin_out,
  input wire logic timer_output_pin_oe_n_out,
  input wire logic compare_a_match_out,
  input wire logic compare_p_match_out,
  input wire logic [9:0] count_out
);
  logic [7:0] ctl;
  logic [3:0] run;
  logic p_clears;
  // Shadows of the two control registers, snooped from the write port.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ctl <= 8'h00;
      run <= 4'h0;
    end else if (write_strobe_in && address_in == 3'h1) begin
      ctl <= write_data_in;
    end else if (write_strobe_in && address_in == 3'h0) begin
      run <= write_data_in[3:0];
    end
  end
  assign p_clears = (ctl[7:6] == 2'h2) ? !ctl[1] : !ctl[0];
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  sequence s_run_rise;
    write_strobe_in && address_in == 3'h0 && write_data_in[3] && !run[3];
  endsequence
  sequence s_idle;
    (!count_tick_in || !run[3]) && !write_strobe_in;
  endsequence
  a_run_rise_clear: assert property (s_run_rise |=> count_out == 10'h000)
    else $error("count not cleared on start");
  a_count_hold: assert property (s_idle |=> $stable(count_out))
    else $error("count moved without a tick");
  a_pin_released: assert property ($past(ctl[6]) |-> timer_output_pin_oe_n_out
    && !timer_output_pin_out) else $error("pin not released");
  a_pin_driven: assert property (!$past(ctl[6]) |-> !timer_output_pin_oe_n_out)
    else $error("pin not driven");
  a_pwm_forced: assert property ($past(ctl[7:6] == 2'h2 && !ctl[5]) |->
    timer_output_pin_out == ($past(ctl[3] ~^ ctl[4]) ^ $past(ctl[2]))) else $error("forced level");
  a_p_suppressed: assert property ($past(ctl[7:6] != 2'h2 && ctl[0]) |->
    !compare_p_match_out) else $error("p match while a clears");
  a_p_clear: assert property (compare_p_match_out && $past(p_clears) |->
    count_out == 10'h000) else $error("p match did not clear");
  a_a_clear: assert property (compare_a_match_out && $past(!p_clears) |->
    count_out == 10'h000) else $error("a match did not clear");
  a_p_period: assert property (compare_p_match_out |-> count_out[6:0] == 7'h00 &&
    (count_out == 10'h000 || count_out[9:7] == $past(run[2:0]))) else $error("p period");
  a_count_high: assert property (read_strobe_in && address_in == 3'h3 |=>
    read_data_out == {6'h00, $past(count_out[9:8])}) else $error("count high read");
endmodule
bind output_initial_level_top output_initial_level_checker i_output_initial_level_checker (.clock_in, .reset_in, .address_in, .write_data_in,
  .write_strobe_in, .read_strobe_in, .count_tick_in, .read_data_out, .timer_output_pin_out,
  .timer_output_pin_oe_n_out, .compare_a_match_out, .compare_p_match_out, .count_out);
`default_nettype wire

// ==== output_initial_level_load_model.sv ====
// Load on the timer output pin, resolving the level seen on the line.
`timescale 1ns/1ps
`default_nettype none
module output_initial_level_load_model (
  input wire logic clock_in,
  input wire logic pin_in,
  input wire logic oe_n_in,
  output logic line_out
);
  logic last = 1'b0;
  always @(posedge clock_in) begin
    last <= line_out;
  end
  // The line has no pull, so a released pin wanders instead of keeping its last level.
  assign line_out = oe_n_in ? ~last : pin_in;
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the compact timer core against a cycle model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [7:0] ctl;
    logic [3:0] run;
    logic [9:0] cmpa;
    logic [7:0] abuf;
    logic [7:0] cbuf;
    logic [9:0] cnt;
    logic lvl;
    logic touched;
    logic [7:0] rd;
    logic pin;
    logic oe;
    logic am;
    logic pm;
  } output_initial_level_bench_model_t;
  output_initial_level_bench_model_t m = '0;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] address_in = 3'h0;
  logic [7:0] write_data_in = 8'h00;
  logic write_strobe_in = 1'b0;
  logic read_strobe_in = 1'b0;
  logic count_tick_in = 1'b0;
  logic [7:0] read_data_out;
  logic [9:0] count_out;
  logic pin, oe_n, a_match, p_match, line, lv, clr;
  logic [31:0] rnd = 32'h2db4;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n, pp, duty;
  output_initial_level_top i_output_initial_level_top (.clock_in, .reset_in, .address_in, .write_data_in, .write_strobe_in,
    .read_strobe_in, .count_tick_in, .read_data_out, .timer_output_pin_out(pin),
    .timer_output_pin_oe_n_out(oe_n), .compare_a_match_out(a_match),
    .compare_p_match_out(p_match), .count_out);
  output_initial_level_load_model i_output_initial_level_load_model (.clock_in, .pin_in(pin), .oe_n_in(oe_n), .line_out(line));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  initial forever #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    rnd <= xs(rnd);
    count_tick_in <= (rnd[2:0] != 3'h0);
  end
  // Outputs are computed from the state before each edge, which is what the core registers.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      m = '0;
    end else begin
      m.rd = 8'h00;
      m.am = 1'b0;
      m.pm = 1'b0;
      lv = m.touched ? m.lvl : m.ctl[3];
      pp = (m.run[2:0] == 3'h0) ? 1024 : int'(m.run[2:0]) * 128;
      duty = m.ctl[1] ? pp : int'(m.cmpa);
      if (m.ctl[7:6] == 2'h0) m.pin = lv ^ m.ctl[2];
      else if (m.ctl[7:6] == 2'h2 && m.ctl[5:4] != 2'h3)
        m.pin = ((m.ctl[5:4] == 2'h2 ? m.cnt < duty : m.ctl[4]) ~^ m.ctl[3]) ^ m.ctl[2];
      else if (m.ctl[6]) m.pin = 1'b0;
      m.oe = m.ctl[6];
      if (read_strobe_in) begin
        case (address_in)
          3'h0: m.rd = {4'h0, m.run};
          3'h1: m.rd = m.ctl;
          3'h2: m.rd = m.cbuf;
          3'h3: begin
            m.rd = {6'h00, m.cnt[9:8]};
            m.cbuf = m.cnt[7:0];
          end
          3'h4: m.rd = m.abuf;
          3'h5: begin
            m.rd = {6'h00, m.cmpa[9:8]};
            m.abuf = m.cmpa[7:0];
          end
          default: m.rd = 8'h00;
        endcase
      end
      if (write_strobe_in && address_in == 3'h0 && write_data_in[3] && !m.run[3]) begin
        m.cnt = 10'h000;
        m.touched = 1'b0;
      end else if (m.run[3] && count_tick_in) begin
        n = int'(m.cnt) + 1;
        m.am = (m.cmpa != 10'h000) && (n == int'(m.cmpa));
        m.pm = (n == pp) && !(m.ctl[7:6] != 2'h2 && m.ctl[0]);
        clr = (m.ctl[7:6] == 2'h2 ? m.ctl[1] : m.ctl[0]) ? m.am : (n == pp);
        m.cnt = clr ? 10'h000 : n[9:0];
        if (m.am && m.ctl[7:6] == 2'h0 && m.ctl[5:4] != 2'h0) begin
          m.lvl = (m.ctl[5:4] == 2'h3) ? ~lv : m.ctl[5];
          m.touched = 1'b1;
        end
      end
      if (write_strobe_in) begin
        case (address_in)
          3'h0: m.run = write_data_in[3:0];
          3'h1: m.ctl = write_data_in;
          3'h4: m.abuf = write_data_in;
          3'h5: m.cmpa = {write_data_in[1:0], m.abuf};
          default: ;
        endcase
      end
    end
  end
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(negedge clock_in) begin
    if (!reset_in) begin
      check("count", m.cnt, count_out);
      check("read", 10'(m.rd), 10'(read_data_out));
      check("a_match", 10'(m.am), 10'(a_match));
      check("p_match", 10'(m.pm), 10'(p_match));
      check("oe_n", 10'(m.oe), 10'(oe_n));
      if (!m.oe) check("pin", 10'(m.pin), 10'(line));
    end
  end
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    address_in <= a;
    write_data_in <= d;
    write_strobe_in <= w;
    read_strobe_in <= !w;
    @(posedge clock_in);
    write_strobe_in <= 1'b0;
    read_strobe_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic set_a(input logic [9:0] v);
    bus(1'b1, 3'h4, v[7:0]);
    bus(1'b1, 3'h5, {6'h00, v[9:8]});
    bus(1'b0, 3'h5, 8'h00);
    bus(1'b0, 3'h4, 8'h00);
  endtask
  // The mode is only ever changed with the timer off, as unreliable output follows otherwise.
  task automatic run_cfg(input logic [7:0] c, input logic [2:0] p, input int cycles);
    bus(1'b1, 3'h0, 8'h00);
    bus(1'b1, 3'h1, c);
    bus(1'b1, 3'h0, {5'h01, p});
    repeat (cycles) @(posedge clock_in);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clock_in);
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    for (int a = 0; a < 8; a++) bus(1'b0, a[2:0], 8'h00);
    $display("Test reset values done");
    set_a(rnd[9:0]);
    run_cfg(8'hc0, 3'h0, 50);
    bus(1'b0, 3'h3, 8'h00);
    bus(1'b0, 3'h2, 8'h00);
    $display("Test register pairs done");
    for (int i = 0; i < 8; i++) begin
      set_a(10'(20 + i));
      run_cfg({2'h0, i[1:0], i[2], rnd[0], 2'h1}, 3'h1, 90);
    end
    $display("Test compare actions done");
    run_cfg(8'h24, 3'h1, 300);
    run_cfg(8'h24, 3'h0, 1300);
    $display("Test counter clearing done");
    for (int i = 0; i < 8; i++) begin
      set_a(i[0] ? 10'h12c : 10'h032);
      run_cfg({2'h2, 2'(i / 2), rnd[1:0], i[0], rnd[2]}, 3'h2, 320);
    end
    $display("Test pulse width done");
    run_cfg(8'h7c, 3'h1, 40);
    run_cfg(8'hfc, 3'h1, 40);
    reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    bus(1'b0, 3'h1, 8'h00);
    $display("Test released modes and reset done");
    finish_test();
  end
endmodule
`default_nettype wire
